// ===== common/pin_routing_cfg.svh
/*
 * Register offsets, field positions, write masks and reset values for the
 * audio port pin routing block.
 * Assumes the includer sees this file by its bare name on the include path.
 */
`ifndef PIN_ROUTING_CFG_SVH
`define PIN_ROUTING_CFG_SVH

// ****************************************
// Offsets, reset values, write masks
// ****************************************
`define ADDR_PIN_FUNC_A   8'h14
`define ADDR_BIAS_PIN     8'h15
`define ADDR_PORT_ENABLE  8'h18
`define ADDR_PIN_ALLOC    8'h19
`define RST_PIN_FUNC_A    8'h00
`define RST_BIAS_PIN      8'h00
`define RST_PORT_ENABLE   8'h40
`define RST_PIN_ALLOC     8'h00
`define WMASK_PIN_FUNC_A  8'hff
`define WMASK_BIAS_PIN    8'hc0
`define WMASK_PORT_ENABLE 8'hff
`define WMASK_PIN_ALLOC   8'hf8

// ****************************************
// Field positions
// ****************************************
`define MIC_OVRD_BIT      7
`define SHARED_OUT_BIT    6
`define ADC_SEL_HI        5
`define ADC_SEL_LO        4
`define DAC_SEL_HI        3
`define DAC_SEL_LO        2
`define POWER_LIMIT_BIT   1
`define GAIN_BIT          0
`define BIAS_SEL_HI       7
`define BIAS_SEL_LO       6
`define PRI_DIS_BIT       7
`define SEC_DIS_BIT       6
`define GANG_BIT          5
`define CHAIN_HI          4
`define CHAIN_LO          3
`define CHAIN_IN_HI       2
`define CHAIN_IN_LO       0
`define OUT_ALLOC_HI      7
`define OUT_ALLOC_LO      6
`define IN_ALLOC_HI       5
`define IN_ALLOC_LO       4
`define CHAIN_DIR_BIT     3

`endif

// ===== common/pin_routing_pkg.sv
/*
 * Types shared by the pin routing block and its helpers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pin_routing_pkg;
    typedef enum logic [1:0] {
        PICK_NONE        = 2'b00,
        PICK_PIN_ONE     = 2'b01,
        PICK_PIN_TWO     = 2'b10,
        PICK_INPUT_THREE = 2'b11
    } pin_pick_t;

    typedef enum logic [1:0] {
        CHAIN_OFF       = 2'b00,
        CHAIN_PRIMARY   = 2'b01,
        CHAIN_SECONDARY = 2'b10,
        CHAIN_RESERVED  = 2'b11
    } chain_mode_t;

    typedef enum logic [1:0] {
        ALLOC_SPLIT     = 2'b00,
        ALLOC_PRIMARY   = 2'b01,
        ALLOC_SECONDARY = 2'b10,
        ALLOC_RESERVED  = 2'b11
    } alloc_t;

    typedef struct packed {
        logic serial_in;
        logic general_input_three;
        logic general_pin_two;
        logic general_pin_one;
    } pins_t;

    typedef struct packed {
        logic       primary_enable;
        logic       secondary_enable;
        logic       secondary_follows_primary;
        logic       chain_dir_input;
        logic [1:0] primary_out_lanes;
        logic [1:0] secondary_out_lanes;
        logic [1:0] primary_in_lanes;
        logic [1:0] secondary_in_lanes;
    } port_status_t;
endpackage : pin_routing_pkg

// ===== design/pin_source_select.sv
/*
 * One pin selector: picks none, first, second or third general input.
 * Assumes pin levels are already synchronous to the system clock.
 */
`timescale 1ns/1ps
module pin_source_select
    import pin_routing_pkg::*;
(
    // Selection
    input  pin_pick_t pick,
    input  pins_t     pins,
    // Result
    output logic      picked
);
    always_comb
    begin
        unique case (pick)
            PICK_NONE:        picked = 1'b0;
            PICK_PIN_ONE:     picked = pins.general_pin_one;
            PICK_PIN_TWO:     picked = pins.general_pin_two;
            PICK_INPUT_THREE: picked = pins.general_input_three;
        endcase
    end
endmodule : pin_source_select

// ===== design/port_plan.sv
/*
 * Decodes port enable, ganging, chaining and pin allocation fields.
 * Assumes raw register bytes from the pin routing register file.
 */
`timescale 1ns/1ps
`include "pin_routing_cfg.svh"
module port_plan
    import pin_routing_pkg::*;
(
    // Register fields
    input  logic [7:0]   enable_chain_reg,
    input  logic [7:0]   pin_alloc_reg,
    // Decoded plan
    output port_status_t status
);
    chain_mode_t chain;
    alloc_t      out_alloc;
    alloc_t      in_alloc;

    // Reserved three falls back to the harmless setting
    assign chain     = chain_mode_t'(enable_chain_reg[`CHAIN_HI:`CHAIN_LO]);
    assign out_alloc = alloc_t'(pin_alloc_reg[`OUT_ALLOC_HI:`OUT_ALLOC_LO]);
    assign in_alloc  = alloc_t'(pin_alloc_reg[`IN_ALLOC_HI:`IN_ALLOC_LO]);

    always_comb
    begin
        status = '0;
        status.primary_enable = !enable_chain_reg[`PRI_DIS_BIT]
            && (chain != CHAIN_SECONDARY);
        status.secondary_enable = !enable_chain_reg[`SEC_DIS_BIT]
            && (chain != CHAIN_PRIMARY);
        status.secondary_follows_primary =
            enable_chain_reg[`GANG_BIT];
        status.chain_dir_input = pin_alloc_reg[`CHAIN_DIR_BIT];
        unique case (out_alloc)
            ALLOC_PRIMARY:   status.primary_out_lanes   = 2'h2;
            ALLOC_SECONDARY: status.secondary_out_lanes = 2'h2;
            default:
            begin
                status.primary_out_lanes   = 2'h1;
                status.secondary_out_lanes = 2'h1;
            end
        endcase
        unique case (in_alloc)
            ALLOC_PRIMARY:   status.primary_in_lanes   = 2'h2;
            ALLOC_SECONDARY: status.secondary_in_lanes = 2'h2;
            default:
            begin
                status.primary_in_lanes   = 2'h1;
                status.secondary_in_lanes = 2'h1;
            end
        endcase
        // One port, one output and one input pin while chaining
        unique case (chain)
            CHAIN_PRIMARY:
            begin
                status.primary_out_lanes   = 2'h1;
                status.primary_in_lanes    = 2'h1;
                status.secondary_out_lanes = 2'h0;
                status.secondary_in_lanes  = 2'h0;
            end
            CHAIN_SECONDARY:
            begin
                status.secondary_out_lanes = 2'h1;
                status.secondary_in_lanes  = 2'h1;
                status.primary_out_lanes   = 2'h0;
                status.primary_in_lanes    = 2'h0;
            end
            default:
            begin
            end
        endcase
    end
endmodule : port_plan

// ===== design/audio_port_pin_routing.sv
/*
 * Pin routing and audio serial port configuration: four control registers
 * on the control port, pin muxing of microphone data, power down, power
 * limit, gain adjust, bias enable, shared output pin and chain input.
 * Assumes pins are synchronous to clk_sys and the control port issues
 * single-cycle read and write strobes.
 */
`timescale 1ns/1ps
`include "pin_routing_cfg.svh"
module audio_port_pin_routing
    import pin_routing_pkg::*;
(
    // Clock and reset
    input  logic         clk_sys,
    input  logic         reset,
    // Control port
    input  logic [7:0]   reg_addr,
    input  logic         reg_write,
    input  logic [7:0]   reg_wdata,
    input  logic         reg_read,
    output logic [7:0]   reg_rdata,
    // Device pins
    input  pins_t        pins,
    input  logic         serial_out_return,
    output logic         serial_out_pin,
    output logic         serial_out_oe,
    // Core side controls
    input  pin_pick_t    mic_pair_a_source,
    input  pin_pick_t    mic_pair_b_source,
    input  logic         adc_register_powerdown,
    input  logic         dac_register_powerdown,
    input  logic         dout_ordinary,
    input  logic         port_tx_data,
    input  logic         port_tx_drive,
    // Routed functions
    output logic         mic_pair_a_data,
    output logic         mic_pair_b_data,
    output logic         adc_powerdown,
    output logic         dac_powerdown,
    output logic         power_limit_function,
    output logic         gain_adjust_function,
    output logic         mic_bias_supply,
    output logic         port_rx_data,
    output logic         chain_in_data,
    output logic         chain_in_valid,
    output port_status_t port_status
);
    localparam int NUM_SEL = 5;

    logic [7:0]   pin_function_config_a;
    logic [7:0]   bias_pin_config;
    logic [7:0]   serial_port_enable_chain;
    logic [7:0]   serial_port_pin_alloc;
    logic         mic_data_select_override;
    logic         shared_out;
    pin_pick_t    picks  [NUM_SEL];
    pins_t        routed [NUM_SEL];
    logic [NUM_SEL-1:0] picked;
    port_status_t next_port_status;
    logic         next_chain_in_data;
    logic         next_chain_in_valid;
    logic [7:0]   next_reg_rdata;

    // ****************************************
    // Register file
    // ****************************************
    // Reserved bits are masked so they always read zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_function_config_a    <= `RST_PIN_FUNC_A;
            bias_pin_config          <= `RST_BIAS_PIN;
            serial_port_enable_chain <= `RST_PORT_ENABLE;
            serial_port_pin_alloc    <= `RST_PIN_ALLOC;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                `ADDR_PIN_FUNC_A:
                    pin_function_config_a <= reg_wdata & `WMASK_PIN_FUNC_A;
                `ADDR_BIAS_PIN:
                    bias_pin_config <= reg_wdata & `WMASK_BIAS_PIN;
                `ADDR_PORT_ENABLE:
                    serial_port_enable_chain <=
                        reg_wdata & `WMASK_PORT_ENABLE;
                `ADDR_PIN_ALLOC:
                    serial_port_pin_alloc <= reg_wdata & `WMASK_PIN_ALLOC;
                default:
                begin
                end
            endcase
        end
    end

    always_comb
    begin
        unique case (reg_addr)
            `ADDR_PIN_FUNC_A:  next_reg_rdata = pin_function_config_a;
            `ADDR_BIAS_PIN:    next_reg_rdata = bias_pin_config;
            `ADDR_PORT_ENABLE: next_reg_rdata = serial_port_enable_chain;
            `ADDR_PIN_ALLOC:   next_reg_rdata = serial_port_pin_alloc;
            default:           next_reg_rdata = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= next_reg_rdata;
    end

    // ****************************************
    // Pin selectors
    // ****************************************
    assign mic_data_select_override = pin_function_config_a[`MIC_OVRD_BIT];
    assign shared_out = pin_function_config_a[`SHARED_OUT_BIT];
    assign picks[0] = mic_pair_a_source;
    assign picks[1] = mic_pair_b_source;
    assign picks[2] =
        pin_pick_t'(pin_function_config_a[`ADC_SEL_HI:`ADC_SEL_LO]);
    assign picks[3] =
        pin_pick_t'(pin_function_config_a[`DAC_SEL_HI:`DAC_SEL_LO]);
    assign picks[4] =
        pin_pick_t'(bias_pin_config[`BIAS_SEL_HI:`BIAS_SEL_LO]);

    generate
        for (genvar i = 0; i < NUM_SEL; i++)
        begin : g_sel
            // Mic pairs only: third input swapped for serial input
            always_comb
            begin
                routed[i] = pins;
                if ((i < 2) && mic_data_select_override)
                    routed[i].general_input_three = pins.serial_in;
            end
            pin_source_select u_sel (
                .pick   (picks[i]),
                .pins   (routed[i]),
                .picked (picked[i])
            );
        end
    endgenerate

    // ****************************************
    // Routed functions
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mic_pair_a_data <= 1'b0;
            mic_pair_b_data <= 1'b0;
        end
        else
        begin
            mic_pair_a_data <= picked[0];
            mic_pair_b_data <= picked[1];
        end
    end

    // Either source may force power down; neither can hold power on
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            adc_powerdown <= 1'b0;
            dac_powerdown <= 1'b0;
        end
        else
        begin
            adc_powerdown <= picked[2] | adc_register_powerdown;
            dac_powerdown <= picked[3] | dac_register_powerdown;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            power_limit_function <= 1'b0;
            gain_adjust_function <= 1'b0;
            mic_bias_supply      <= 1'b0;
        end
        else
        begin
            power_limit_function <= pin_function_config_a[`POWER_LIMIT_BIT]
                && pins.general_pin_one;
            gain_adjust_function <= pin_function_config_a[`GAIN_BIT]
                && pins.general_pin_one;
            mic_bias_supply <= picked[4];
        end
    end

    // With shared_out set the pin drives only while the port transmits; otherwise it always drives
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            serial_out_pin <= 1'b0;
            serial_out_oe  <= 1'b0;
            port_rx_data   <= 1'b0;
        end
        else if (shared_out)
        begin
            serial_out_pin <= port_tx_data;
            serial_out_oe  <= port_tx_drive;
            port_rx_data   <= serial_out_return;
        end
        else
        begin
            serial_out_pin <= dout_ordinary;
            serial_out_oe  <= 1'b1;
            port_rx_data   <= pins.serial_in;
        end
    end

    // ****************************************
    // Port plan and chain input
    // ****************************************
    port_plan u_plan (
        .enable_chain_reg (serial_port_enable_chain),
        .pin_alloc_reg    (serial_port_pin_alloc),
        .status           (next_port_status)
    );

    // Reserved codes leave the chain input disabled
    always_comb
    begin
        next_chain_in_valid = 1'b1;
        case (serial_port_enable_chain[`CHAIN_IN_HI:`CHAIN_IN_LO])
            3'h1:    next_chain_in_data = pins.general_pin_one;
            3'h2:    next_chain_in_data = pins.general_pin_two;
            3'h3:    next_chain_in_data = pins.general_input_three;
            3'h5:    next_chain_in_data = pins.serial_in;
            default:
            begin
                next_chain_in_data  = 1'b0;
                next_chain_in_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            port_status    <= '0;
            chain_in_data  <= 1'b0;
            chain_in_valid <= 1'b0;
        end
        else
        begin
            port_status    <= next_port_status;
            chain_in_data  <= next_chain_in_data;
            chain_in_valid <= next_chain_in_valid;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_mic_override;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && $past(mic_data_select_override)
            && $past(mic_pair_a_source) == PICK_INPUT_THREE)
            |-> mic_pair_a_data == $past(pins.serial_in);
    endproperty
    a_mic_override: assert property (p_mic_override)
        else $error("mic pair a ignored override");

    property p_shared_out;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && $past(shared_out))
            |-> port_rx_data == $past(serial_out_return)
                && serial_out_pin == $past(port_tx_data);
    endproperty
    a_shared_out: assert property (p_shared_out)
        else $error("shared output pin misrouted");

    property p_adc_pd;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && $past(adc_register_powerdown)) |-> adc_powerdown;
    endproperty
    a_adc_pd: assert property (p_adc_pd)
        else $error("adc register power down lost");

    property p_dac_pd;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && !$past(dac_register_powerdown)
            && $past(picks[3]) == PICK_NONE) |-> !dac_powerdown;
    endproperty
    a_dac_pd: assert property (p_dac_pd)
        else $error("dac powered down without cause");

    property p_power_limit;
        @(posedge clk_sys) disable iff (reset)
        !$past(pin_function_config_a[`POWER_LIMIT_BIT])
            |-> !power_limit_function;
    endproperty
    a_power_limit: assert property (p_power_limit)
        else $error("power limit active while pin control off");

    property p_gain;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && $past(pin_function_config_a[`GAIN_BIT]))
            |-> gain_adjust_function == $past(pins.general_pin_one);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain adjust not following first pin");

    property p_bias;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset) && $past(picks[4]) == PICK_PIN_TWO)
            |-> mic_bias_supply == $past(pins.general_pin_two);
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias enable not following second pin");

    property p_reset_ports;
        @(posedge clk_sys)
        $fell(reset) |-> serial_port_enable_chain[`PRI_DIS_BIT] == 1'b0
            && serial_port_enable_chain[`SEC_DIS_BIT] == 1'b1;
    endproperty
    a_reset_ports: assert property (p_reset_ports)
        else $error("port disable bits wrong after reset");

    property p_chain_excl;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset)
            && ($past(serial_port_enable_chain[`CHAIN_HI:`CHAIN_LO]) == 2'h1
            || $past(serial_port_enable_chain[`CHAIN_HI:`CHAIN_LO]) == 2'h2))
            |-> !(port_status.primary_enable
                && port_status.secondary_enable);
    endproperty
    a_chain_excl: assert property (p_chain_excl)
        else $error("both ports enabled while chaining");

    property p_out_alloc;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset)
            && $past(serial_port_pin_alloc[`OUT_ALLOC_HI:`OUT_ALLOC_LO])
                == 2'h1
            && $past(serial_port_enable_chain[`CHAIN_HI:`CHAIN_LO]) == 2'h0)
            |-> port_status.primary_out_lanes == 2'h2
                && port_status.secondary_out_lanes == 2'h0;
    endproperty
    a_out_alloc: assert property (p_out_alloc)
        else $error("output lanes not paired on primary");

    property p_chain_in;
        @(posedge clk_sys) disable iff (reset)
        (!$past(reset)
            && $past(serial_port_enable_chain[`CHAIN_IN_HI:`CHAIN_IN_LO])
                == 3'h4) |-> !chain_in_valid && !chain_in_data;
    endproperty
    a_chain_in: assert property (p_chain_in)
        else $error("reserved chain input code not disabled");
endmodule : audio_port_pin_routing

// ===== bench/test_audio_port_pin_routing.sv
/*
 * Self-checking bench for audio_port_pin_routing: register access and
 * pin routing through the control port strobes.
 * Assumes the package and header are compiled and on the include path.
 */
`timescale 1ns/1ps
`include "pin_routing_cfg.svh"
module test_audio_port_pin_routing
    import pin_routing_pkg::*;
;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic         clk_sys = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic         reg_write = 1'b0;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_read = 1'b0;
    logic [7:0]   reg_rdata;
    pins_t        pins = 4'h0;
    logic         serial_out_return = 1'b0;
    logic         serial_out_pin, serial_out_oe;
    pin_pick_t    mic_a = PICK_NONE;
    pin_pick_t    mic_b = PICK_NONE;
    logic         adc_reg_pd = 1'b0;
    logic         dac_reg_pd = 1'b0;
    logic         dout_ordinary = 1'b0;
    logic         port_tx_data = 1'b0;
    logic         port_tx_drive = 1'b0;
    logic         mic_a_d, mic_b_d, adc_pd, dac_pd, pwr_lim, gain, bias;
    logic         port_rx_data, chain_in_data, chain_in_valid;
    port_status_t st;
    int           fail_count = 0;
    int           checked = 0;
    logic [7:0]   addrs [4] = '{8'h14, 8'h15, 8'h18, 8'h19};
    logic [7:0]   rstv [4] = '{8'h00, 8'h00, 8'h40, 8'h00};
    // Write patterns keep reserved bits clear and codes legal
    logic [7:0]   maskv [4] = '{8'hff, 8'hc0, 8'hf5, 8'ha8};
    // Chain input code to the one pin it must follow
    logic [3:0]   cin_map [8] = '{4'h0, 4'h1, 4'h2, 4'h4,
                                  4'h0, 4'h8, 4'h0, 4'h0};
    logic [3:0]   sel;
    logic [1:0]   po, so;

    always #5 clk_sys = ~clk_sys;

    audio_port_pin_routing dut (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pins(pins),
        .serial_out_return(serial_out_return),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .mic_pair_a_source(mic_a), .mic_pair_b_source(mic_b),
        .adc_register_powerdown(adc_reg_pd),
        .dac_register_powerdown(dac_reg_pd),
        .dout_ordinary(dout_ordinary), .port_tx_data(port_tx_data),
        .port_tx_drive(port_tx_drive), .mic_pair_a_data(mic_a_d),
        .mic_pair_b_data(mic_b_d), .adc_powerdown(adc_pd),
        .dac_powerdown(dac_pd), .power_limit_function(pwr_lim),
        .gain_adjust_function(gain), .mic_bias_supply(bias),
        .port_rx_data(port_rx_data), .chain_in_data(chain_in_data),
        .chain_in_valid(chain_in_valid), .port_status(st));

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string what, input logic [11:0] exp,
             input logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
    endtask : wr

    // Read data is registered, so it is looked at one edge later
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk_sys);
        reg_read = 1'b0;
        chk("reg_rdata", {4'h0, exp}, {4'h0, reg_rdata});
    endtask : rd

    // Outputs lag register writes and pins by up to two edges
    task settle;
        repeat (2) @(negedge clk_sys);
    endtask : settle

    task conclude;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        settle();
        chk("primary_enable", 10'h1, st.primary_enable);
        chk("secondary_enable", 10'h0, st.secondary_enable);
        for (int i = 0; i < 4; i++)
            rd(addrs[i], rstv[i]);
        for (int i = 0; i < 4; i++)
        begin
            wr(addrs[i], maskv[i]);
            rd(addrs[i], maskv[i]);
        end
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h14, {2'b00, k[1:0], k[1:0], 2'b00});
            wr(8'h15, {k[1:0], 6'h00});
            sel = (k == 0) ? 4'h0 : (4'h1 << (k - 1));
            for (int p = 0; p < 2; p++)
            begin
                pins = p ? sel : (4'hf ^ sel);
                settle();
                chk("adc_powerdown", p && k != 0, adc_pd);
                chk("dac_powerdown", p && k != 0, dac_pd);
                chk("mic_bias_supply", p && k != 0, bias);
                chk("power_limit", 10'h0, pwr_lim);
                chk("gain_adjust", 10'h0, gain);
            end
        end
        adc_reg_pd = 1'b1;
        dac_reg_pd = 1'b1;
        settle();
        chk("adc_powerdown", 10'h1, adc_pd);
        chk("dac_powerdown", 10'h1, dac_pd);
        adc_reg_pd = 1'b0;
        dac_reg_pd = 1'b0;
        wr(8'h14, 8'h03);
        for (int p = 0; p < 2; p++)
        begin
            pins = p ? 4'h1 : 4'he;
            settle();
            chk("power_limit", p, pwr_lim);
            chk("gain_adjust", p, gain);
        end
        wr(8'h14, 8'hc0);
        mic_a = PICK_INPUT_THREE;
        mic_b = PICK_PIN_TWO;
        pins = 4'h8;
        port_tx_data = 1'b1;
        port_tx_drive = 1'b1;
        serial_out_return = 1'b1;
        settle();
        chk("mic_pair_a_data", 10'h1, mic_a_d);
        chk("mic_pair_b_data", 10'h0, mic_b_d);
        chk("serial_out", 10'h3, {serial_out_pin, serial_out_oe});
        chk("port_rx_data", 10'h1, port_rx_data);
        port_tx_drive = 1'b0;
        settle();
        chk("serial_out_oe", 10'h0, serial_out_oe);
        wr(8'h14, 8'h00);
        serial_out_return = 1'b0;
        dout_ordinary = 1'b1;
        settle();
        chk("mic_pair_a_data", 10'h0, mic_a_d);
        chk("serial_out", 12'h3, {serial_out_pin, serial_out_oe});
        chk("port_rx_data", 10'h1, port_rx_data);
        wr(8'h18, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h19, {k[1:0], k[1:0], k[0], 3'b000});
            po = (k == 1) ? 2'd2 : (k == 2) ? 2'd0 : 2'd1;
            so = (k == 1) ? 2'd0 : (k == 2) ? 2'd2 : 2'd1;
            settle();
            chk("port_status", {3'b110, k[0], po, so, po, so}, st);
        end
        wr(8'h19, 8'h00);
        wr(8'h18, 8'h28);
        settle();
        chk("port_status", 12'b1010_01_00_01_00, st);
        wr(8'h18, 8'h10);
        settle();
        chk("port_status", 12'b0100_00_01_00_01, st);
        wr(8'h18, 8'h80);
        settle();
        chk("port_status", 12'b0100_01_01_01_01, st);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h18, {5'b00001, c[2:0]});
            for (int p = 0; p < 2; p++)
            begin
                pins = p ? cin_map[c] : (4'hf ^ cin_map[c]);
                settle();
                chk("chain_in_valid", cin_map[c] != 0, chain_in_valid);
                chk("chain_in_data", p && cin_map[c] != 0, chain_in_data);
            end
        end
        conclude();
    end
endmodule : test_audio_port_pin_routing
